// file: shared/debug_exit_params.svh
`ifndef DEBUG_EXIT_PARAMS_SVH
`define DEBUG_EXIT_PARAMS_SVH
// Scan chain layout: flag is the top bit, shifted first
`define CHAIN_LEN        33
`define INSTR_LEN        32
`define SPEED_FLAG_BIT   32
`define NOP_WORD         32'hE1A00000
`define BRANCH_BASE      32'hEA000000
`define BRANCH_OFS_MASK  32'h00FFFFFF
// Program counter advances in addresses; breakpoint sizes in bytes
`define PC_ENTRY_BKPT    32'h00000004
`define PC_ENTRY_WATCH   32'h00000004
`define PC_ENTRY_REQ     32'h00000004
`define PC_PER_DEBUG     32'h00000001
`define PC_PER_SYSTEM    32'h00000005
`define BKPT_BYTES_FULL  32'h00000010
`define BKPT_BYTES_HALF  32'h00000008
`define REFETCH_COUNT    2'h3
// Link clock divider half period in system clocks
`define TCK_HALF_DIV     4'h4
`endif

// file: shared/debug_exit_pkg.sv
package debug_exit_pkg;
  typedef enum logic [1:0] {
    ENTRY_BREAKPOINT,
    ENTRY_WATCHPOINT,
    ENTRY_REQUEST
  } entry_cause_type;

  typedef enum {
    CORE_RUN,
    CORE_DEBUG,
    CORE_SYSTEM,
    CORE_REFETCH
  } core_state_type;
endpackage : debug_exit_pkg

// file: shared/debug_link_if.sv
`timescale 1ns/1ps
interface debug_link_if;
  logic tck;
  logic tdi;
  logic capture;
  logic restart_sel;
  logic run_idle;
  logic tdo;

  modport debugger (
    output tck,
    output tdi,
    output capture,
    output restart_sel,
    output run_idle,
    input  tdo
  );
  modport device (
    input  tck,
    input  tdi,
    input  capture,
    input  restart_sel,
    input  run_idle,
    output tdo
  );
endinterface : debug_link_if

// file: src/edge_sync.sv
`timescale 1ns/1ps
module edge_sync (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic async_in,
  output logic      level_out,
  output logic      rise_out
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level_out = sync_r;
  assign rise_out  = sync_r & ~prev_r;
endmodule : edge_sync

// file: src/debug_exit_core.sv
//======================================================================
`timescale 1ns/1ps
module debug_exit_core #(
  parameter int FETCH_CYCLES = 2
) (
  input  wire logic                            clk,
  input  wire logic                            reset_n,
  debug_link_if.device                         link,
  input  wire logic                            enter_debug,
  input  wire debug_exit_pkg::entry_cause_type entry_cause,
  input  wire logic                            half_width_state,
  input  wire logic                            abort_pending,
  input  wire logic                            exception_pending,
  input  wire logic                            access_abort,
  output logic                                 debug_acknowledge,
  output logic                                 fetch_strobe,
  output logic                                 abort_mode,
  output logic                                 exception_mode,
  output logic [31:0]                          pc_value,
  output logic [31:0]                          pc_bytes,
  output logic [31:0]                          last_instr
);
`include "debug_exit_params.svh"

  //====================================================================
  // Link inputs pass two flops before use
  logic tck_rise;
  logic tdi_lvl;
  logic cap_lvl;
  logic rst_sel_lvl;
  logic idle_rise;

  edge_sync u_tck (.clk(clk), .reset_n(reset_n), .async_in(link.tck),
    .level_out(), .rise_out(tck_rise));
  edge_sync u_tdi (.clk(clk), .reset_n(reset_n), .async_in(link.tdi),
    .level_out(tdi_lvl), .rise_out());
  edge_sync u_cap (.clk(clk), .reset_n(reset_n), .async_in(link.capture),
    .level_out(cap_lvl), .rise_out());
  edge_sync u_sel (.clk(clk), .reset_n(reset_n),
    .async_in(link.restart_sel), .level_out(rst_sel_lvl),
    .rise_out());
  edge_sync u_idl (.clk(clk), .reset_n(reset_n), .async_in(link.run_idle),
    .level_out(), .rise_out(idle_rise));

  //====================================================================
  // Scan chain and pipeline load
  logic [`CHAIN_LEN-1:0]      chain_r;
  logic                       cap_d_r;
  logic                       load_pulse;
  logic                       flag_pending_r;
  debug_exit_pkg::core_state_type state_r;

  assign load_pulse = cap_lvl & ~cap_d_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      chain_r <= '0;
      cap_d_r <= 1'b0;
    end else begin
      cap_d_r <= cap_lvl;
      if (tck_rise && !cap_lvl && state_r == debug_exit_pkg::CORE_DEBUG)
        chain_r <= {chain_r[`CHAIN_LEN-2:0], tdi_lvl};
    end
  end

  // Loaded speed flag; dropped whenever the core leaves debug
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_pending_r <= 1'b0;
      last_instr     <= '0;
    end else if (load_pulse && state_r == debug_exit_pkg::CORE_DEBUG) begin
      flag_pending_r <= chain_r[`SPEED_FLAG_BIT];
      last_instr     <= chain_r[`INSTR_LEN-1:0];
    end else if (state_r != debug_exit_pkg::CORE_DEBUG) begin
      flag_pending_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      link.tdo <= 1'b0;
    else
      link.tdo <= chain_r[`CHAIN_LEN-1];
  end

  //====================================================================
  // Core state and acknowledge
  logic [1:0] fetch_cnt_r;
  logic [3:0] cyc_r;
  logic       sys_mode_r;
  logic       fetch_now;
  logic       resume;
  logic       sys_done_r;

  assign fetch_now = (cyc_r == 4'(FETCH_CYCLES - 1));
  // Resume only on run-idle entry so several cores can restart together
  assign resume = idle_rise & rst_sel_lvl & flag_pending_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r     <= debug_exit_pkg::CORE_RUN;
      fetch_cnt_r <= '0;
      cyc_r       <= '0;
      sys_mode_r  <= 1'b0;
    end else begin
      cyc_r <= fetch_now ? '0 : cyc_r + 4'h1;
      case (state_r)
        debug_exit_pkg::CORE_RUN: begin
          // Held off while an abort or exception is still being taken
          if (enter_debug && !abort_pending && !exception_pending)
            state_r <= debug_exit_pkg::CORE_DEBUG;
        end
        debug_exit_pkg::CORE_DEBUG: begin
          if (resume) begin
            sys_mode_r  <= 1'b1;
            fetch_cnt_r <= '0;
            // System access returns to debug by itself
            state_r <= (last_instr == `NOP_WORD && sys_mode_r)
                       ? debug_exit_pkg::CORE_REFETCH
                       : debug_exit_pkg::CORE_SYSTEM;
          end
        end
        debug_exit_pkg::CORE_SYSTEM: begin
          if (fetch_now)
            state_r <= debug_exit_pkg::CORE_DEBUG;
        end
        debug_exit_pkg::CORE_REFETCH: begin
          if (fetch_now) begin
            fetch_cnt_r <= fetch_cnt_r + 2'h1;
            if (fetch_cnt_r == `REFETCH_COUNT - 2'h1) begin
              state_r    <= debug_exit_pkg::CORE_RUN;
              sys_mode_r <= 1'b0;
            end
          end
        end
        default: state_r <= debug_exit_pkg::CORE_RUN;
      endcase
    end
  end

  // One cycle low after a system access, in the cycle after its strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      debug_acknowledge <= 1'b0;
      fetch_strobe      <= 1'b0;
      sys_done_r        <= 1'b0;
    end else begin
      sys_done_r <= state_r == debug_exit_pkg::CORE_SYSTEM && fetch_now;
      debug_acknowledge <= state_r != debug_exit_pkg::CORE_RUN &&
                           !sys_done_r;
      fetch_strobe <= fetch_now &&
                      state_r != debug_exit_pkg::CORE_DEBUG;
    end
  end

  //====================================================================
  // Exception modes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      abort_mode     <= 1'b0;
      exception_mode <= 1'b0;
    end else begin
      if (state_r == debug_exit_pkg::CORE_SYSTEM && access_abort)
        abort_mode <= 1'b1;
      else if (state_r == debug_exit_pkg::CORE_RUN && abort_pending)
        abort_mode <= 1'b1;
      else if (state_r == debug_exit_pkg::CORE_REFETCH)
        abort_mode <= 1'b0;
      // Sticky: debug is entered in the mode of the exception taken
      if (state_r == debug_exit_pkg::CORE_RUN && exception_pending)
        exception_mode <= 1'b1;
      else if (state_r == debug_exit_pkg::CORE_REFETCH)
        exception_mode <= 1'b0;
    end
  end

  //====================================================================
  // Program counter tracking
  function automatic logic [31:0] entry_adv(
    input debug_exit_pkg::entry_cause_type c);
    case (c)
      debug_exit_pkg::ENTRY_WATCHPOINT: entry_adv = `PC_ENTRY_WATCH;
      debug_exit_pkg::ENTRY_REQUEST:    entry_adv = `PC_ENTRY_REQ;
      default:                          entry_adv = `PC_ENTRY_BKPT;
    endcase
  endfunction : entry_adv

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_value <= '0;
      pc_bytes <= '0;
    end else if (state_r == debug_exit_pkg::CORE_RUN && enter_debug &&
                 !abort_pending && !exception_pending) begin
      pc_value <= pc_value + entry_adv(entry_cause);
      pc_bytes <= half_width_state ? `BKPT_BYTES_HALF
                                   : `BKPT_BYTES_FULL;
    end else if (state_r == debug_exit_pkg::CORE_DEBUG && load_pulse) begin
      pc_value <= pc_value + `PC_PER_DEBUG;
    end else if (state_r == debug_exit_pkg::CORE_SYSTEM && fetch_now) begin
      pc_value <= pc_value + `PC_PER_SYSTEM;
    end else if (state_r == debug_exit_pkg::CORE_REFETCH && fetch_now &&
                 fetch_cnt_r == `REFETCH_COUNT - 2'h1) begin
      pc_value <= '0;
    end
  end
endmodule : debug_exit_core

// file: src/debug_exit_host.sv
`timescale 1ns/1ps
module debug_exit_host (
  input  wire logic        clk,
  input  wire logic        reset_n,
  debug_link_if.debugger   link,
  input  wire logic        start,
  input  wire logic [31:0] debug_count,
  input  wire logic [31:0] system_count,
  output logic             busy,
  output logic             done
);
`include "debug_exit_params.svh"

  typedef enum {
    H_IDLE, H_SHIFT, H_LOAD, H_RESTART, H_IDLE_ENTER
  } host_state_type;

  host_state_type        st_r;
  logic [`CHAIN_LEN-1:0] sh_r;
  logic [5:0]            bits_r;
  logic                  second_r;
  logic [3:0]            div_r;
  logic [31:0]           ofs;
  logic [31:0]           branch_word;

  // Return offset covers entry, debug ops incl. branch, system ops
  assign ofs = 32'h0 - (`PC_ENTRY_BKPT + debug_count +
               `PC_PER_SYSTEM * system_count);
  assign branch_word = `BRANCH_BASE | (ofs & `BRANCH_OFS_MASK);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r             <= H_IDLE;
      sh_r             <= '0;
      bits_r           <= '0;
      second_r         <= 1'b0;
      div_r            <= '0;
      link.tck         <= 1'b0;
      link.tdi         <= 1'b0;
      link.capture     <= 1'b0;
      link.restart_sel <= 1'b0;
      link.run_idle    <= 1'b0;
      busy             <= 1'b0;
      done             <= 1'b0;
    end else begin
      done  <= 1'b0;
      div_r <= (div_r == `TCK_HALF_DIV - 4'h1) ? '0 : div_r + 4'h1;
      case (st_r)
        H_IDLE: begin
          if (start) begin
            // Run-idle is a level: it stays up until the next sequence
            link.run_idle    <= 1'b0;
            // Branch first with the flag clear
            sh_r             <= {1'b0, branch_word};
            bits_r           <= '0;
            second_r         <= 1'b0;
            busy             <= 1'b1;
            link.restart_sel <= 1'b0;
            st_r             <= H_SHIFT;
          end
        end
        H_SHIFT: if (div_r == '0) begin
          if (!link.tck) begin
            link.tdi <= sh_r[`CHAIN_LEN-1];
            link.tck <= 1'b1;
          end else begin
            link.tck <= 1'b0;
            sh_r     <= {sh_r[`CHAIN_LEN-2:0], 1'b0};
            bits_r   <= bits_r + 6'h1;
            if (bits_r == 6'(`CHAIN_LEN - 1))
              st_r <= H_LOAD;
          end
        end
        H_LOAD: if (div_r == '0) begin
          if (!link.capture) begin
            link.capture <= 1'b1;
          end else begin
            link.capture <= 1'b0;
            bits_r       <= '0;
            if (!second_r) begin
              sh_r     <= {1'b1, `NOP_WORD};
              second_r <= 1'b1;
              st_r     <= H_SHIFT;
            end else begin
              st_r <= H_RESTART;
            end
          end
        end
        H_RESTART: if (div_r == '0) begin
          link.restart_sel <= 1'b1;
          st_r             <= H_IDLE_ENTER;
        end
        H_IDLE_ENTER: if (div_r == '0) begin
          link.run_idle <= 1'b1;
          busy          <= 1'b0;
          done          <= 1'b1;
          st_r          <= H_IDLE;
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end
endmodule : debug_exit_host

// file: testbench/debug_exit_sva.sv
`timescale 1ns/1ps
module debug_exit_sva (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tck,
  input wire logic tdi,
  input wire logic capture,
  input wire logic restart_sel,
  input wire logic run_idle,
  input wire logic debug_acknowledge,
  input wire logic fetch_strobe
);
  logic [3:0] fetches_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  //====================================================================
  // Fetch counter
  // Restarts on each resume so a stale count never leaks into the next
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fetches_r <= 4'h0;
    end else if ($rose(run_idle)) begin
      fetches_r <= 4'h0;
    end else if (fetch_strobe && fetches_r != 4'hF) begin
      fetches_r <= fetches_r + 4'h1;
    end
  end

  //====================================================================
  // Assertions
  chk_link_half_period: assert property (
    $rose(tck) |-> tck [*4] ##1 !tck)
    else $error("link clock high phase is not four cycles");
  chk_tdi_held_high: assert property (
    tck && $past(tck) |-> $stable(tdi))
    else $error("scan bit moved while link clock high");
  chk_capture_once: assert property (
    $rose(capture) |-> capture [*4] ##1 !capture)
    else $error("capture pulse is not a single four cycle load");
  chk_capture_in_debug: assert property (
    $rose(capture) |-> debug_acknowledge)
    else $error("load into pipeline outside debug state");
  chk_sel_before_idle: assert property (
    $rose(restart_sel) |-> !run_idle ##[1:8] run_idle)
    else $error("run-idle not entered shortly after leave select");
  chk_idle_needs_sel: assert property (
    $rose(run_idle) |-> $past(restart_sel))
    else $error("run-idle entered without leave select");
  chk_wait_for_idle: assert property (
    $rose(restart_sel) |-> (debug_acknowledge && !fetch_strobe) [*5])
    else $error("resumed before run-idle was entered");
  chk_ack_on_resume: assert property (
    $rose(run_idle) |-> debug_acknowledge [*3])
    else $error("acknowledge dropped right at resume");
  chk_three_refetch: assert property (
    $fell(debug_acknowledge) ##1 !debug_acknowledge |->
      $past(fetches_r) == 4'h3)
    else $error("acknowledge fell after a wrong number of fetches");

  cov_resume: cover property ($rose(run_idle));
  cov_refetch: cover property (fetch_strobe && debug_acknowledge);
  cov_ack_fall: cover property ($fell(debug_acknowledge));
  cov_sys_dip: cover property ($fell(debug_acknowledge) ##1 debug_acknowledge);
endmodule : debug_exit_sva

// file: testbench/debug_exit_pc_tracking_tb.sv
`timescale 1ns/1ps
`include "debug_exit_params.svh"
module debug_exit_pc_tracking_tb;
  logic        clk, reset_n, enter_debug, half_width_state;
  logic        abort_pending, exception_pending, access_abort, start;
  logic        debug_acknowledge, fetch_strobe, abort_mode, exception_mode;
  logic        busy, done;
  logic [31:0] debug_count, system_count, pc_value, pc_bytes, last_instr;
  int          fails, comparisons;
  debug_exit_pkg::entry_cause_type entry_cause;

  debug_link_if link ();
  debug_exit_core debug_exit_core_inst (.clk(clk), .reset_n(reset_n),
    .link(link), .enter_debug(enter_debug), .entry_cause(entry_cause),
    .half_width_state(half_width_state), .abort_pending(abort_pending),
    .exception_pending(exception_pending), .access_abort(access_abort),
    .debug_acknowledge(debug_acknowledge), .fetch_strobe(fetch_strobe),
    .abort_mode(abort_mode), .exception_mode(exception_mode),
    .pc_value(pc_value),
    .pc_bytes(pc_bytes), .last_instr(last_instr));
  debug_exit_host debug_exit_host_inst (.clk(clk), .reset_n(reset_n),
    .link(link), .start(start), .debug_count(debug_count),
    .system_count(system_count), .busy(busy), .done(done));
  debug_exit_sva debug_exit_sva_inst (.clk(clk), .reset_n(reset_n),
    .tck(link.tck), .tdi(link.tdi), .capture(link.capture),
    .restart_sel(link.restart_sel), .run_idle(link.run_idle),
    .debug_acknowledge(debug_acknowledge), .fetch_strobe(fetch_strobe));

  //====================================================================
  // Helpers
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic run_host();
    int   k;
    logic seen;
    seen = 1'b0;
    debug_count = 32'h00000003;
    system_count = 32'h00000000;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    cmp({31'h0, busy}, 32'h00000001);
    for (k = 0; k < 3000 && done !== 1'b1; k++) begin
      tick(1);
      // Two debug ops plus the branch: back seven addresses
      if (last_instr === 32'hEAFFFFF9) seen = 1'b1;
    end
    cmp({31'h0, seen}, 32'h00000001);
    cmp({31'h0, done}, 32'h00000001);
    cmp({31'h0, busy}, 32'h00000000);
  endtask : run_host

  //====================================================================
  // Scenarios
  task automatic sc_entry(input debug_exit_pkg::entry_cause_type c,
                          input logic h, input logic held);
    int k;
    entry_cause = c;
    half_width_state = h;
    abort_pending = held;
    exception_pending = held;
    enter_debug = 1'b1;
    tick(20);
    if (held) begin
      cmp({31'h0, debug_acknowledge}, 32'h0);
      abort_pending = 1'b0;
      tick(20);
      cmp({31'h0, debug_acknowledge}, 32'h0);
      exception_pending = 1'b0;
    end
    for (k = 0; k < 200 && debug_acknowledge !== 1'b1; k++) tick(1);
    enter_debug = 1'b0;
    cmp({31'h0, debug_acknowledge}, 32'h1);
    cmp(pc_value, `PC_ENTRY_WATCH);
    cmp({31'h0, abort_mode}, {31'h0, held});
    cmp({31'h0, exception_mode}, {31'h0, held});
    if (c == debug_exit_pkg::ENTRY_BREAKPOINT)
      cmp(pc_bytes, h ? `BKPT_BYTES_HALF : `BKPT_BYTES_FULL);
  endtask : sc_entry

  // First return after entry runs one system access and stays in debug
  task automatic sc_system(input logic abrt, input logic prior_abort);
    int          k;
    logic        dip;
    logic [31:0] pc_exp;
    dip = 1'b0;
    pc_exp = `PC_ENTRY_BKPT + `PC_PER_DEBUG + `PC_PER_DEBUG + `PC_PER_SYSTEM;
    access_abort = abrt;
    run_host();
    for (k = 0; k < 50; k++) begin
      if (debug_acknowledge === 1'b0) dip = 1'b1;
      tick(1);
    end
    cmp({31'h0, dip}, 32'h00000001);
    cmp({31'h0, debug_acknowledge}, 32'h1);
    cmp(last_instr, `NOP_WORD);
    cmp(pc_value, pc_exp);
    cmp({31'h0, abort_mode}, {31'h0, abrt | prior_abort});
    access_abort = 1'b0;
  endtask : sc_system

  task automatic sc_resume();
    int k, n;
    n = 0;
    run_host();
    for (k = 0; k < 300 && debug_acknowledge !== 1'b0; k++) begin
      if (fetch_strobe === 1'b1) n++;
      tick(1);
    end
    cmp(n, {30'h0, `REFETCH_COUNT});
    cmp({31'h0, debug_acknowledge}, 32'h0);
  endtask : sc_resume

  task automatic final_report();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report

  //====================================================================
  // Clock, stimulus and watchdog
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    {reset_n, enter_debug, half_width_state, start} = 4'h0;
    {abort_pending, exception_pending, access_abort} = 3'h0;
    debug_count = 32'h0;
    system_count = 32'h0;
    entry_cause = debug_exit_pkg::ENTRY_BREAKPOINT;
    repeat (3) @(posedge clk);
    #1;
    reset_n = 1'b1;
    tick(3);
    sc_entry(debug_exit_pkg::ENTRY_BREAKPOINT, 1'b0, 1'b1);
    sc_system(1'b0, 1'b1);
    sc_resume();
    sc_entry(debug_exit_pkg::ENTRY_BREAKPOINT, 1'b1, 1'b0);
    sc_system(1'b1, 1'b0);
    sc_resume();
    sc_entry(debug_exit_pkg::ENTRY_WATCHPOINT, 1'b0, 1'b0);
    sc_system(1'b0, 1'b0);
    sc_resume();
    sc_entry(debug_exit_pkg::ENTRY_REQUEST, 1'b0, 1'b0);
    sc_system(1'b0, 1'b0);
    sc_resume();
    final_report();
  end

  // Four entries with two returns each need well under 20000 cycles
  initial begin
    #240000;
    fails++;
    final_report();
  end
endmodule : debug_exit_pc_tracking_tb
